/* verilog/pmt_pkg.sv */
// Shared constants and types for the power-management timer
package pmt_pkg;
  localparam int unsigned PMT_COUNT_W = 24;
  localparam int unsigned PMT_BYTE_W = 8;
  localparam int unsigned PMT_ADDR_W = 16;
  localparam int unsigned PMT_OFF_W = 4;
  localparam logic [3:0] PMT_OFF_LOW = 4'h8;
  localparam logic [3:0] PMT_OFF_MID = 4'h9;
  localparam logic [3:0] PMT_OFF_UPP = 4'hA;
  localparam logic [23:0] PMT_COUNT_RST = 24'h000000;
  localparam logic [7:0] PMT_BYTE_RST = 8'h00;
  localparam int unsigned PMT_TOP_BIT = 23;
  localparam int unsigned PMT_MID_LSB = 8;
  localparam int unsigned PMT_UPP_LSB = 16;
  localparam logic [15:0] PMT_BASE_RST = 16'h0000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
  } pmt_io_req_t;
endpackage

/* verilog/pmt_tick_edge.sv */
// Rising-edge detector turning the reference clock level into a tick
`timescale 1ns/10ps
`default_nettype none
module pmt_tick_edge (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic tick_o
);
  logic last_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Track the level so a reference high at release gives no tick
      last_q <= level_i;
      tick_o <= 1'b0;
    end else begin
      last_q <= level_i;
      tick_o <= level_i & ~last_q;
    end
  end

  tick_single_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o)
    else $error("tick lasted two cycles");
endmodule
`default_nettype wire

/* verilog/pmt_timer.sv */
// Power-management 24-bit timer with byte-wide read-only I/O view
// Notes on behaviour
// - 24-bit counter advances on each reference tick.
// - Reset clears count; then counts while clocked.
// - Stopped reference holds count; restart continues.
// - Flag set on every bit 23 transition.
// - Enabled flag drives system control interrupt.
// - Offsets 9h, Ah return bits 15:8, 23:16.
`timescale 1ns/10ps
`default_nettype none
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int unsigned COUNT_W = PMT_COUNT_W
) (
  // Clock and master reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reference clock level (3.579545 MHz), sampled in clk_i
  input wire logic reference_clock_input_i,
  // Base address from the two configuration registers
  input wire logic [7:0] pm_base_address_high_cfg_i,
  input wire logic [7:0] pm_base_address_low_cfg_i,
  // Host I/O request
  input wire pmt_io_req_t io_req_i,
  // Read answer
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // Flag handshake with the status/enable block
  input wire logic pm_rollover_flag_clr_i,
  input wire logic pm_rollover_irq_enable_i,
  output logic pm_rollover_flag_o,
  output logic sci_irq_o,
  // Live count
  output logic [23:0] pm_count_value_o
);
  // Narrower counters only serve test builds; bytes above read zero
  if (COUNT_W < 2 || COUNT_W > PMT_COUNT_W) begin : g_bad_width
    $error("pmt_timer: counter width must be 2 to 24 bits");
  end

  // Bits above the counter width stay zero in every byte view
  localparam logic [23:0] COUNT_MASK =
    24'((25'h0000001 << COUNT_W) - 25'h0000001);
  localparam int unsigned TOP_BIT = COUNT_W - 1;

  logic tick;
  logic [15:0] base;
  logic hit;
  logic [3:0] off;
  logic top_prev_q;
  logic top_toggle;

  // Reference clock runs well below clk_i, so an edge tick is safe
  pmt_tick_edge u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(reference_clock_input_i),
    .tick_o(tick)
  );

  // No tick while the reference is stopped, so the count simply holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_count_value_o <= PMT_COUNT_RST;
    end else if (tick) begin
      // Masked so a narrow build wraps at its own width
      pm_count_value_o <= (pm_count_value_o + 24'h000001) &
                          COUNT_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_prev_q <= 1'b0;
    end else begin
      top_prev_q <= pm_count_value_o[TOP_BIT];
    end
  end

  assign top_toggle = pm_count_value_o[TOP_BIT] ^ top_prev_q;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_rollover_flag_o <= 1'b0;
    end else if (top_toggle) begin
      pm_rollover_flag_o <= 1'b1;
    end else if (pm_rollover_flag_clr_i) begin
      pm_rollover_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sci_irq_o <= 1'b0;
    end else begin
      sci_irq_o <= pm_rollover_irq_enable_i &
                   (pm_rollover_flag_o | top_toggle);
    end
  end

  assign base = {pm_base_address_high_cfg_i, pm_base_address_low_cfg_i};
  assign off = 4'(io_req_i.addr - base);
  assign hit = (io_req_i.addr >= base) &&
               ((io_req_i.addr - base) < 16'h0010);

  // Writes never reach the counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_rdata_o <= PMT_BYTE_RST;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= 1'b0;
      io_rdata_o <= PMT_BYTE_RST;
      if (io_req_i.rd && hit) begin
        case (off)
          PMT_OFF_LOW: begin
            io_rvalid_o <= 1'b1;
            io_rdata_o <= pm_count_value_o[7:0];
          end
          PMT_OFF_MID: begin
            io_rvalid_o <= 1'b1;
            io_rdata_o <=
              pm_count_value_o[PMT_MID_LSB +: PMT_BYTE_W];
          end
          PMT_OFF_UPP: begin
            io_rvalid_o <= 1'b1;
            io_rdata_o <=
              pm_count_value_o[PMT_UPP_LSB +: PMT_BYTE_W];
          end
          default: begin
            io_rdata_o <= PMT_BYTE_RST;
          end
        endcase
      end
    end
  end

  // A read request, taken on one edge and answered on the next
  sequence read_at_s(logic [3:0] which);
    io_req_i.rd && hit && off == which;
  endsequence

  // Flag path: toggle seen, then flag and interrupt in the same cycle
  sequence top_moved_s;
    top_toggle && pm_rollover_irq_enable_i;
  endsequence

  sequence flag_and_irq_s;
    pm_rollover_flag_o && sci_irq_o;
  endsequence

  count_step_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick |=> pm_count_value_o ==
      (($past(pm_count_value_o) + 24'h000001) & COUNT_MASK))
    else $error("count did not step");
  count_reset_a: assert property (
    @(posedge clk_i)
    rst_i |=> pm_count_value_o == PMT_COUNT_RST)
    else $error("count not cleared");
  count_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !tick |=> $stable(pm_count_value_o))
    else $error("count moved without tick");
  flag_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    top_toggle |=> pm_rollover_flag_o)
    else $error("flag missed top bit toggle");
  flag_cause_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(pm_rollover_flag_o) |-> $past(top_toggle))
    else $error("flag set without toggle");
  flag_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pm_rollover_flag_clr_i && !top_toggle) |=> !pm_rollover_flag_o)
    else $error("flag not cleared");
  flag_sticky_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!pm_rollover_flag_clr_i && !top_toggle)
    |=> $stable(pm_rollover_flag_o))
    else $error("flag changed on its own");
  irq_gate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pm_rollover_irq_enable_i && pm_rollover_flag_o) |=> sci_irq_o)
    else $error("interrupt not raised");
  irq_mask_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !pm_rollover_irq_enable_i |=> !sci_irq_o)
    else $error("masked interrupt raised");
  irq_same_cycle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    top_moved_s |=> flag_and_irq_s)
    else $error("interrupt lagged the flag");
  upper_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    read_at_s(PMT_OFF_UPP)
    |=> io_rvalid_o && io_rdata_o == $past(pm_count_value_o[23:16]))
    else $error("upper byte wrong");
  mid_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    read_at_s(PMT_OFF_MID)
    |=> io_rvalid_o && io_rdata_o == $past(pm_count_value_o[15:8]))
    else $error("middle byte wrong");
  stray_offset_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (io_req_i.rd && (off < PMT_OFF_LOW || off > PMT_OFF_UPP))
    |=> !io_rvalid_o)
    else $error("answer outside timer bytes");
  low_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    read_at_s(PMT_OFF_LOW)
    |=> io_rvalid_o && io_rdata_o == $past(pm_count_value_o[7:0]))
    else $error("low byte wrong");
  write_ignored_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (io_req_i.wr && !io_req_i.rd) |=> !io_rvalid_o)
    else $error("write answered");
  idle_bus_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !io_req_i.rd |=> (!io_rvalid_o && io_rdata_o == PMT_BYTE_RST))
    else $error("answer without read");
  data_gated_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !io_rvalid_o |-> io_rdata_o == PMT_BYTE_RST)
    else $error("data without valid");
endmodule
`default_nettype wire

/* verif/pmt_timer_bench.sv */
// Self-checking bench for the power-management timer
`timescale 1ns/10ps
`default_nettype none
module pmt_timer_bench;
  import pmt_pkg::*;
  typedef struct {
    int tk;
    logic [3:0] off;
    logic wr;
    logic v;
    logic [7:0] d;
  } pmt_row_t;
  logic clk_i;
  logic rst_i;
  logic ref_clk;
  logic clr;
  logic en;
  pmt_io_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic flag;
  logic irq;
  logic [23:0] cnt;
  logic flag_n;
  logic irq_n;
  logic [23:0] cnt_n;
  int bad_count;
  int n_tests;
  // Ticks to add, offset, write, expected valid and byte
  pmt_row_t rows [9] = '{
    '{0, 4'h8, 1'b0, 1'b1, 8'h00}, '{0, 4'h9, 1'b0, 1'b1, 8'h00},
    '{0, 4'hA, 1'b0, 1'b1, 8'h00}, '{5, 4'h8, 1'b0, 1'b1, 8'h05},
    '{300, 4'h9, 1'b0, 1'b1, 8'h01}, '{0, 4'h8, 1'b1, 1'b0, 8'h00},
    '{0, 4'h8, 1'b0, 1'b1, 8'h31}, '{0, 4'hB, 1'b0, 1'b0, 8'h00},
    '{0, 4'hA, 1'b0, 1'b1, 8'h00}};
  pmt_timer dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reference_clock_input_i(ref_clk),
    .pm_base_address_high_cfg_i(8'h12),
    .pm_base_address_low_cfg_i(8'h30),
    .io_req_i(req),
    .io_rdata_o(rdata),
    .io_rvalid_o(rvalid),
    .pm_rollover_flag_clr_i(clr),
    .pm_rollover_irq_enable_i(en),
    .pm_rollover_flag_o(flag),
    .sci_irq_o(irq),
    .pm_count_value_o(cnt)
  );
  // Narrow copy: its top bit toggles within a short run
  pmt_timer #(
    .COUNT_W(9)
  ) dut_narrow (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reference_clock_input_i(ref_clk),
    .pm_base_address_high_cfg_i(8'h12),
    .pm_base_address_low_cfg_i(8'h30),
    .io_req_i(req),
    .io_rdata_o(),
    .io_rvalid_o(),
    .pm_rollover_flag_clr_i(clr),
    .pm_rollover_irq_enable_i(en),
    .pm_rollover_flag_o(flag_n),
    .sci_irq_o(irq_n),
    .pm_count_value_o(cnt_n)
  );
  task automatic check(logic [23:0] seen, logic [23:0] exp, string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Two system clocks per reference period, then let the count settle
  task automatic tick(int n);
    repeat (n) begin
      @(negedge clk_i) ref_clk = 1'b1;
      @(negedge clk_i) ref_clk = 1'b0;
    end
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rd(logic [3:0] off, logic wr, logic v, logic [7:0] d);
    req = '{rd: !wr, wr: wr, addr: 16'h1230 + 16'(off)};
    @(negedge clk_i);
    req = '0;
    check(rvalid, v, "rvalid");
    check(rdata, d, "rdata");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #(25 * 20000);
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_i = 1'b1;
    ref_clk = 1'b0;
    clr = 1'b0;
    en = 1'b1;
    req = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    check(cnt, 24'h0, "count");
    foreach (rows[i]) begin
      tick(rows[i].tk);
      rd(rows[i].off, rows[i].wr, rows[i].v, rows[i].d);
    end
    // Reference parked high: one edge counted, then it must hold
    ref_clk = 1'b1;
    repeat (20) @(negedge clk_i);
    check(cnt, 24'd306, "held");
    ref_clk = 1'b0;
    tick(4);
    check(cnt, 24'd310, "resumed");
    // Back-to-back reads of two bytes
    req = '{rd: 1'b1, wr: 1'b0, addr: 16'h1238};
    @(negedge clk_i);
    req = '{rd: 1'b1, wr: 1'b0, addr: 16'h1239};
    check(rdata, 8'h36, "low");
    @(negedge clk_i);
    req = '0;
    check(rdata, 8'h01, "mid");
    // Bit 23 never moved, so no flag and no interrupt
    check({flag, irq}, 2'b00, "flag");
    // Narrow copy passed 256, so its top bit rose
    check({flag_n, irq_n}, 2'b11, "narrow flag");
    check(cnt_n, 24'd310, "narrow count");
    en = 1'b0;
    @(negedge clk_i);
    check({flag_n, irq_n}, 2'b10, "masked irq");
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    en = 1'b1;
    check(flag_n, 1'b0, "flag clear");
    // Wrap of the narrow copy: top bit falls
    tick(202);
    check(cnt_n, 24'h0, "narrow wrap");
    check({flag_n, irq_n}, 2'b11, "falling bit");
    check(cnt, 24'd512, "count");
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    check(cnt, 24'h0, "reset");
    check({flag_n, irq_n}, 2'b00, "narrow reset");
    tick(1);
    check(cnt, 24'h1, "count");
    end_of_test();
  end
endmodule
`default_nettype wire
